//--- include/knock_pkg.sv
// constants for the knock response controller
package knock_pkg;
  localparam int DATA_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RETARD_LIMIT = 8'h04;
  localparam logic [7:0] OFS_STOP_LIMIT = 8'h08;
  localparam logic [7:0] OFS_GAIN = 8'h0c;
  localparam logic [7:0] OFS_DECAY = 8'h10;
  localparam logic [7:0] OFS_CEILING = 8'h14;
  localparam logic [7:0] OFS_HOLD = 8'h18;
  localparam logic [7:0] OFS_WIN_DELAY = 8'h1c;
  localparam logic [7:0] OFS_WIN_LEN = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h2c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h30;
  // control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_BAD_EN = 1;
  localparam int CTRL_GATE_EN = 2;
  localparam int CTRL_W = 3;
  // interrupt bit positions
  localparam int IRQ_KNOCK = 0;
  localparam int IRQ_LOAD = 1;
  localparam int IRQ_TRIP = 2;
  localparam int IRQ_BAD = 3;
  localparam int IRQ_W = 4;
  // values after reset
  localparam logic [CTRL_W-1:0] RST_CTRL = 3'h0;
  localparam logic [15:0] RST_RETARD_LIMIT = 16'h4000;
  localparam logic [15:0] RST_STOP_LIMIT = 16'hc000;
  localparam logic [15:0] RST_GAIN = 16'h0100;
  localparam logic [15:0] RST_DECAY = 16'h0040;
  localparam logic [15:0] RST_CEILING = 16'h1000;
  localparam logic [15:0] RST_HOLD = 16'h2710;
  localparam logic [15:0] RST_WIN_DELAY = 16'h0010;
  localparam logic [15:0] RST_WIN_LEN = 16'h0100;
  // hold delay counts in milliseconds
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_TICK_NS = 1000000;
  localparam int HOLD_TICK_CYCLES = HOLD_TICK_NS / CLK_PERIOD_NS;
endpackage : knock_pkg

//--- design/knock_response_control.sv
// knock response controller with apb registers and interrupt
`timescale 1ns/1ps
`default_nettype none
module knock_response_control #(
  parameter int TICK_CYCLES = knock_pkg::HOLD_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ignitionPulse,
  input wire logic combustionGate,
  input wire logic [15:0] knockEnergy,
  input wire logic energyValid,
  input wire logic sensorFaulty,
  input wire logic sensorSilent,
  output logic knockOut,
  output logic loadReduce,
  output logic tripOut,
  output logic badSensor,
  output logic [15:0] retardValue,
  output logic windowOpen,
  output logic irq
);
  typedef enum logic [3:0] {
    W_IDLE = 4'h1,
    W_DELAY = 4'h2,
    W_FIRST = 4'h4,
    W_SECOND = 4'h8
  } win_e;

  logic [knock_pkg::CTRL_W-1:0] ctrl_q;
  logic [15:0] retardLimit_q, stopLimit_q, gain_q, decay_q, ceiling_q, hold_q;
  logic [15:0] winDelay_q, winLen_q;
  logic [knock_pkg::IRQ_W-1:0] irqStat_q, irqEn_q, irqEvt, irqClr;
  logic [1:0] pulseSync_q, gateSync_q;
  logic pulsePrev_q, pulseRise;
  win_e win_q;
  logic [15:0] winCnt_q, peak_q;
  logic evalPulse;
  logic knockNow, stopNow;
  logic [16:0] retardSum;
  logic [15:0] holdCnt_q;
  logic [31:0] tickCnt_q;
  logic tick;
  logic stopHit_q;
  logic knockPrev_q, loadPrev_q, tripPrev_q, badPrev_q;
  logic wrEn, rdEn, mapped;

  // pins from the engine are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pulseSync_q <= 2'h0;
      gateSync_q <= 2'h0;
      pulsePrev_q <= 1'b0;
    end else begin
      pulseSync_q <= {pulseSync_q[0], ignitionPulse};
      gateSync_q <= {gateSync_q[0], combustionGate};
      pulsePrev_q <= pulseSync_q[1];
    end
  end
  assign pulseRise = pulseSync_q[1] & ~pulsePrev_q;

  // window sequencer; a pulse during a sequence is ignored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      win_q <= W_IDLE;
      winCnt_q <= 16'h0;
    end else begin
      case (win_q)
        W_IDLE: begin
          if (pulseRise && ctrl_q[knock_pkg::CTRL_RUN] &&
              (gateSync_q[1] || !ctrl_q[knock_pkg::CTRL_GATE_EN])) begin
            win_q <= W_DELAY;
            winCnt_q <= winDelay_q;
          end
        end
        W_DELAY: begin
          if (winCnt_q <= 16'h1) begin
            win_q <= W_FIRST;
            winCnt_q <= winLen_q;
          end else begin
            winCnt_q <= winCnt_q - 16'h1;
          end
        end
        W_FIRST: begin
          if (winCnt_q <= 16'h1) begin
            win_q <= W_SECOND;
            winCnt_q <= winLen_q;
          end else begin
            winCnt_q <= winCnt_q - 16'h1;
          end
        end
        W_SECOND: begin
          if (winCnt_q <= 16'h1) begin
            win_q <= W_IDLE;
          end else begin
            winCnt_q <= winCnt_q - 16'h1;
          end
        end
        default: begin
          win_q <= W_IDLE;
        end
      endcase
    end
  end
  assign windowOpen = (win_q == W_FIRST) || (win_q == W_SECOND);
  assign evalPulse = (win_q == W_SECOND) && (winCnt_q <= 16'h1);

  // peak band energy over both windows of the cylinder
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      peak_q <= 16'h0;
    end else if (win_q == W_DELAY) begin
      peak_q <= 16'h0;
    end else if (windowOpen && energyValid && knockEnergy > peak_q) begin
      peak_q <= knockEnergy;
    end
  end
  assign knockNow = peak_q >= retardLimit_q;
  assign stopNow = peak_q > stopLimit_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      knockOut <= 1'b0;
    end else if (evalPulse) begin
      knockOut <= knockNow;
    end
  end

  // millisecond tick for the post delay
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tickCnt_q <= 32'h0;
    end else if (tick) begin
      tickCnt_q <= 32'h0;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h1;
    end
  end
  assign tick = tickCnt_q == 32'(TICK_CYCLES - 1);

  // retard ramp
  assign retardSum = {1'b0, retardValue} + {1'b0, gain_q};
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      retardValue <= 16'h0;
    end else if (evalPulse) begin
      if (knockNow) begin
        if (retardSum >= {1'b0, ceiling_q}) begin
          retardValue <= ceiling_q;
        end else begin
          retardValue <= retardSum[15:0];
        end
      end else if (holdCnt_q != 16'h0 || loadReduce) begin
        // held while the engine climbs back to full load
        retardValue <= (retardValue > ceiling_q) ? ceiling_q : retardValue;
      end else if (retardValue > decay_q) begin
        retardValue <= retardValue - decay_q;
      end else begin
        retardValue <= 16'h0;
      end
    end
  end

  // load reduction and its trailing hold
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      loadReduce <= 1'b0;
    end else if (evalPulse) begin
      if (knockNow && retardValue >= ceiling_q) begin
        loadReduce <= 1'b1;
      end else if (!knockNow) begin
        loadReduce <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      holdCnt_q <= 16'h0;
    end else if (loadReduce) begin
      holdCnt_q <= hold_q;
    end else if (tick && holdCnt_q != 16'h0) begin
      holdCnt_q <= holdCnt_q - 16'h1;
    end
  end

  // sensor health and trip
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      badSensor <= 1'b0;
    end else begin
      badSensor <= ctrl_q[knock_pkg::CTRL_BAD_EN] & sensorFaulty & ~sensorSilent;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stopHit_q <= 1'b0;
      tripOut <= 1'b0;
    end else begin
      if (evalPulse) begin
        stopHit_q <= stopNow;
      end
      tripOut <= (evalPulse ? stopNow : stopHit_q) | badSensor;
    end
  end

  // interrupt status: rising edges of the outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      knockPrev_q <= 1'b0;
      loadPrev_q <= 1'b0;
      tripPrev_q <= 1'b0;
      badPrev_q <= 1'b0;
    end else begin
      knockPrev_q <= knockOut;
      loadPrev_q <= loadReduce;
      tripPrev_q <= tripOut;
      badPrev_q <= badSensor;
    end
  end
  assign irqEvt = {badSensor & ~badPrev_q, tripOut & ~tripPrev_q,
                   loadReduce & ~loadPrev_q, knockOut & ~knockPrev_q};

  // apb slave, no wait states
  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  // read data staged in the setup cycle so it stands while pready is high
  assign rdEn = psel && !penable && !pwrite;
  // unmapped addresses answer with an error in the access cycle
  assign mapped = (paddr <= knock_pkg::OFS_IRQ_ENABLE) && (paddr[1:0] == 2'h0);
  assign irqClr = (wrEn && paddr == knock_pkg::OFS_IRQ_CLEAR) ?
                  pwdata[knock_pkg::IRQ_W-1:0] : '0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
    end
  end
  assign irq = |(irqStat_q & irqEn_q);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= knock_pkg::RST_CTRL;
      retardLimit_q <= knock_pkg::RST_RETARD_LIMIT;
      stopLimit_q <= knock_pkg::RST_STOP_LIMIT;
      gain_q <= knock_pkg::RST_GAIN;
      decay_q <= knock_pkg::RST_DECAY;
      ceiling_q <= knock_pkg::RST_CEILING;
      hold_q <= knock_pkg::RST_HOLD;
      winDelay_q <= knock_pkg::RST_WIN_DELAY;
      winLen_q <= knock_pkg::RST_WIN_LEN;
      irqEn_q <= '0;
    end else if (wrEn) begin
      case (paddr)
        knock_pkg::OFS_CTRL: ctrl_q <= pwdata[knock_pkg::CTRL_W-1:0];
        knock_pkg::OFS_RETARD_LIMIT: retardLimit_q <= pwdata[15:0];
        knock_pkg::OFS_STOP_LIMIT: stopLimit_q <= pwdata[15:0];
        knock_pkg::OFS_GAIN: gain_q <= pwdata[15:0];
        knock_pkg::OFS_DECAY: decay_q <= pwdata[15:0];
        knock_pkg::OFS_CEILING: ceiling_q <= pwdata[15:0];
        knock_pkg::OFS_HOLD: hold_q <= pwdata[15:0];
        knock_pkg::OFS_WIN_DELAY: winDelay_q <= pwdata[15:0];
        knock_pkg::OFS_WIN_LEN: winLen_q <= pwdata[15:0];
        knock_pkg::OFS_IRQ_ENABLE: irqEn_q <= pwdata[knock_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !mapped;
      if (rdEn) begin
        case (paddr)
          knock_pkg::OFS_CTRL: prdata <= {29'h0, ctrl_q};
          knock_pkg::OFS_RETARD_LIMIT: prdata <= {16'h0, retardLimit_q};
          knock_pkg::OFS_STOP_LIMIT: prdata <= {16'h0, stopLimit_q};
          knock_pkg::OFS_GAIN: prdata <= {16'h0, gain_q};
          knock_pkg::OFS_DECAY: prdata <= {16'h0, decay_q};
          knock_pkg::OFS_CEILING: prdata <= {16'h0, ceiling_q};
          knock_pkg::OFS_HOLD: prdata <= {16'h0, hold_q};
          knock_pkg::OFS_WIN_DELAY: prdata <= {16'h0, winDelay_q};
          knock_pkg::OFS_WIN_LEN: prdata <= {16'h0, winLen_q};
          knock_pkg::OFS_STATUS: prdata <= {peak_q, retardValue[11:0], badSensor,
                                            tripOut, loadReduce, knockOut};
          knock_pkg::OFS_IRQ_STATUS: prdata <= {28'h0, irqStat_q};
          knock_pkg::OFS_IRQ_CLEAR: prdata <= 32'h0;
          knock_pkg::OFS_IRQ_ENABLE: prdata <= {28'h0, irqEn_q};
          default: begin
            prdata <= 32'h0;
          end
        endcase
      end
    end
  end
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence evalKnock;
    evalPulse && knockNow;
  endsequence

  chk_knock_flag: assert property (evalPulse |=> knockOut == $past(knockNow))
    else $error("knock flag does not follow the compare");
  chk_retard_rise: assert property (evalKnock ##0 (retardSum < {1'b0, ceiling_q})
      |=> retardValue == $past(retardSum[15:0]))
    else $error("retard did not rise by gain");
  chk_retard_decay: assert property (evalPulse && !knockNow && !loadReduce
      && holdCnt_q == 16'h0 && retardValue > decay_q
      |=> retardValue == $past(retardValue) - $past(decay_q))
    else $error("retard did not decay by step");
  chk_retard_ceiling: assert property (evalKnock |=> retardValue <= ceiling_q)
    else $error("retard beyond ceiling");
  chk_load_set: assert property (evalKnock ##0 retardValue >= ceiling_q
      |=> loadReduce)
    else $error("load reduction missing");
  chk_load_clear: assert property (evalPulse && !knockNow |=> !loadReduce)
    else $error("load reduction stuck");
  chk_hold_start: assert property ($fell(loadReduce) |-> holdCnt_q == $past(hold_q))
    else $error("hold not started");
  chk_trip_stop: assert property (evalPulse && stopNow |=> tripOut)
    else $error("trip missing on stop limit");
  chk_bad_silent: assert property (sensorSilent |=> !badSensor)
    else $error("silent sensor reported bad");
  chk_bad_trip: assert property (badSensor |=> tripOut)
    else $error("bad sensor without trip");
  sequence firstEnds;
    (win_q == W_FIRST) && (winCnt_q <= 16'h1);
  endsequence

  chk_window_pair: assert property (firstEnds |=> win_q == W_SECOND)
    else $error("second window missing");
  chk_window_after: assert property (windowOpen |-> $past(win_q) != W_IDLE)
    else $error("window opened without pulse");
  chk_irq_hold: assert property (irqEvt[knock_pkg::IRQ_KNOCK] |=>
      irqStat_q[knock_pkg::IRQ_KNOCK])
    else $error("knock event lost");
endmodule : knock_response_control
`default_nettype wire

//--- verif/knock_front_model.sv
// ignition source and band energy front end model
`timescale 1ns/1ps
`default_nettype none
module knock_front_model (
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic [15:0] level,
  input wire logic windowOpen,
  output logic ignitionPulse,
  output logic [15:0] knockEnergy,
  output logic energyValid,
  output logic [7:0] winCycles
);
  logic [2:0] step_q;
  initial begin
    step_q = 3'h0;
    ignitionPulse = 1'b0;
    knockEnergy = 16'h0000;
    energyValid = 1'b0;
    winCycles = 8'h00;
  end
  always @(posedge ref_clk) begin
    if (fire) begin
      // pre-ignition burst ahead of the pulse, must never count
      step_q <= 3'h4;
      energyValid <= 1'b1;
      knockEnergy <= 16'hffff;
      winCycles <= 8'h00;
    end else begin
      if (step_q != 3'h0) step_q <= step_q - 3'h1;
      ignitionPulse <= (step_q > 3'h1);
      energyValid <= windowOpen;
      // outside windows the bus wanders, no stale value to lean on
      knockEnergy <= windowOpen ? level : ~knockEnergy;
      if (windowOpen) winCycles <= winCycles + 8'h01;
    end
  end
endmodule : knock_front_model
`default_nettype wire

//--- verif/knock_response_control_tb_top.sv
// testbench for the knock response controller
`timescale 1ns/1ps
`default_nettype none
module knock_response_control_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic slvErr;
  logic pready, pslverr, ignitionPulse, energyValid, knockOut, loadReduce, tripOut;
  logic badSensor, windowOpen, irq;
  logic combustionGate = 1'b1, sensorFaulty = 1'b0, sensorSilent = 1'b0;
  logic [15:0] level = 16'h0, knockEnergy, retardValue;
  logic [7:0] winCycles;
  logic [15:0] ramp [3] = '{16'h01c0, 16'h02c0, 16'h0300};
  int bad_count = 0, checks = 0;
  always #5 ref_clk = ~ref_clk;
  knock_response_control #(.TICK_CYCLES(10)) dut_u (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ignitionPulse(ignitionPulse),
    .combustionGate(combustionGate), .knockEnergy(knockEnergy), .energyValid(energyValid),
    .sensorFaulty(sensorFaulty), .sensorSilent(sensorSilent), .knockOut(knockOut),
    .loadReduce(loadReduce), .tripOut(tripOut), .badSensor(badSensor),
    .retardValue(retardValue), .windowOpen(windowOpen), .irq(irq));
  knock_front_model front_u (.ref_clk(ref_clk), .fire(fire), .level(level),
    .windowOpen(windowOpen), .ignitionPulse(ignitionPulse), .knockEnergy(knockEnergy),
    .energyValid(energyValid), .winCycles(winCycles));
  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    slvErr = pslverr;
    if (n >= 20) begin
      bad_count++;
      complete_run();
    end
    penable <= 1'b0;
    psel <= 1'b0;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr
  // read data and error are taken at the access edge
  task automatic rd(input logic [7:0] a);
    acc(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_win(input logic v);
    int n;
    n = 0;
    while (windowOpen !== v) begin
      @(posedge ref_clk);
      n++;
      if (n > 60) begin
        bad_count++;
        complete_run();
      end
    end
  endtask : wait_win
  task automatic cyc(input logic [15:0] lv);
    @(posedge ref_clk);
    level <= lv;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    wait_win(1'b1);
    wait_win(1'b0);
    repeat (4) @(posedge ref_clk);
  endtask : cyc
  task automatic t_reset;
    chk({knockOut, loadReduce, tripOut, retardValue}, 32'h0);
    rd(knock_pkg::OFS_RETARD_LIMIT);
    chk(q, {16'h0, knock_pkg::RST_RETARD_LIMIT});
    chk(slvErr, 32'h0);
    rd(8'h3c);
    chk(q, 32'h0);
    chk(slvErr, 32'h1);
    wr(knock_pkg::OFS_IRQ_STATUS, 32'hf);
    rd(knock_pkg::OFS_IRQ_STATUS);
    chk(q, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_knock;
    wr(knock_pkg::OFS_WIN_DELAY, 32'h2);
    wr(knock_pkg::OFS_WIN_LEN, 32'h4);
    wr(knock_pkg::OFS_GAIN, 32'h100);
    wr(knock_pkg::OFS_DECAY, 32'h40);
    wr(knock_pkg::OFS_CEILING, 32'h300);
    wr(knock_pkg::OFS_HOLD, 32'h5);
    wr(knock_pkg::OFS_IRQ_ENABLE, 32'h4);
    wr(knock_pkg::OFS_CTRL, 32'h1);
    cyc(16'h4000);
    chk(winCycles, 32'h8);
    chk({knockOut, loadReduce, tripOut}, 32'h4);
    chk(retardValue, 32'h100);
    cyc(16'h3fff);
    chk({knockOut, retardValue}, 32'h00c0);
    for (int i = 0; i < 3; i++) begin
      cyc(16'h8000);
      chk({loadReduce, retardValue}, {16'h0, ramp[i]});
    end
    cyc(16'h8000);
    chk({loadReduce, retardValue}, 32'h10300);
    cyc(16'h0100);
    chk({knockOut, loadReduce, retardValue}, 32'h0300);
    cyc(16'h0100);
    chk(retardValue, 32'h0300);
    repeat (60) @(posedge ref_clk);
    cyc(16'h0100);
    chk(retardValue, 32'h02c0);
    $display("knock test done");
  endtask : t_knock
  task automatic t_trip_irq;
    cyc(16'hc000);
    chk(tripOut, 32'h0);
    cyc(16'hc001);
    chk({tripOut, irq}, 32'h3);
    rd(knock_pkg::OFS_IRQ_STATUS);
    chk(q[2], 32'h1);
    cyc(16'h0100);
    wr(knock_pkg::OFS_IRQ_CLEAR, 32'h4);
    rd(knock_pkg::OFS_IRQ_STATUS);
    chk({q[2], irq}, 32'h0);
    wr(knock_pkg::OFS_IRQ_ENABLE, 32'h0);
    cyc(16'hc001);
    chk({tripOut, irq}, 32'h2);
    wr(knock_pkg::OFS_IRQ_CLEAR, 32'hf);
    cyc(16'h0100);
    $display("trip test done");
  endtask : t_trip_irq
  task automatic t_bad;
    wr(knock_pkg::OFS_CTRL, 32'h3);
    sensorSilent <= 1'b1;
    sensorFaulty <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({badSensor, tripOut}, 32'h0);
    sensorSilent <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({badSensor, tripOut}, 32'h3);
    wr(knock_pkg::OFS_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
    chk({badSensor, tripOut}, 32'h0);
    sensorFaulty <= 1'b0;
    $display("bad sensor test done");
  endtask : t_bad
  task automatic t_gate;
    wr(knock_pkg::OFS_CTRL, 32'h5);
    combustionGate <= 1'b0;
    repeat (4) @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk(winCycles, 32'h0);
    combustionGate <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cyc(16'h4000);
    chk({winCycles, knockOut}, 32'h11);
    $display("gate test done");
  endtask : t_gate
  task automatic t_mid_reset;
    cyc(16'h8000);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk({knockOut, loadReduce, tripOut, retardValue}, 32'h0);
    rd(knock_pkg::OFS_CTRL);
    chk(q, {29'h0, knock_pkg::RST_CTRL});
    $display("mid reset test done");
  endtask : t_mid_reset
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_knock();
    t_trip_irq();
    t_bad();
    t_gate();
    t_mid_reset();
    complete_run();
  end
endmodule : knock_response_control_tb_top
`default_nettype wire
